/* File: verilog/ttm_thermal_monitor.sv */
// thermal threshold monitor control with wishbone register slave
// Behaviour
// - six warning levels, each flag, sense, mask
// - crossing a threshold sets its flag
// - unmasked set flag pulls interrupt low
// - sense releases only 5 C below threshold
// - shutdown threshold crossing starts regulator shutdown
// - no restart until shutdown hysteresis crossed
// - enable bit turns monitor off/on, except that shutdown keeps it powered
// - always-on bit keeps monitor on in run
// - otherwise 450 us on every 3.0 ms
// - standby always samples, only when enabled
// - comparators debounced 10 us both ways
module ttm_thermal_monitor #(
  parameter int SAMPLE_INTERVAL = ttm_pkg::SAMPLE_INTERVAL_CYC,
  parameter int SAMPLE_WINDOW = ttm_pkg::SAMPLE_WINDOW_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic run_state_i,
  input wire logic [ttm_pkg::NUM_WARN-1:0] warn_rise_cmp_i,
  input wire logic [ttm_pkg::NUM_WARN-1:0] warn_fall_cmp_i,
  input wire logic sd_trip_cmp_i,
  input wire logic sd_release_cmp_i,
  output logic mon_power_o,
  output logic thermal_shutdown_o,
  output logic irq_out_n_o
);
  import ttm_pkg::*;

  localparam int NUM_CMP = 2 * NUM_WARN + 2;

  // control registers
  logic temp_monitor_enable;
  logic temp_monitor_always_on;
  logic [NUM_WARN-1:0] thermal_warn_irq_mask;
  logic [NUM_WARN-1:0] thermal_warn_irq_flag;
  logic [NUM_WARN-1:0] thermal_warn_sense;
  logic next_enable;
  logic next_always_on;
  logic [NUM_WARN-1:0] next_mask;
  logic [NUM_WARN-1:0] next_flag;
  logic [NUM_WARN-1:0] next_sense;

  // bus
  logic [31:0] next_dat;
  logic next_ack;
  logic wr_commit;
  logic flag_wr;
  logic [NUM_WARN-1:0] flag_clr;
  logic [NUM_WARN-1:0] warn_rise;

  // sampling and shutdown
  logic [SAMPLE_CNT_W-1:0] sample_cnt;
  logic [SAMPLE_CNT_W-1:0] next_sample_cnt;
  logic window;
  logic next_mon_power;
  logic next_shutdown;
  logic next_irq_n;

  // debounced comparators
  logic [NUM_CMP-1:0] cmp_raw;
  logic [NUM_CMP-1:0] cmp_clear;
  logic [NUM_CMP-1:0] cmp_lvl;
  logic [NUM_WARN-1:0] rise_lvl;
  logic [NUM_WARN-1:0] fall_lvl;
  logic sd_trip_lvl;
  logic sd_release_lvl;

  assign cmp_raw = {sd_release_cmp_i, sd_trip_cmp_i, warn_fall_cmp_i, warn_rise_cmp_i};
  assign cmp_clear = {2'b00, {(2 * NUM_WARN){~temp_monitor_enable}}};
  assign rise_lvl = cmp_lvl[NUM_WARN-1:0];
  assign fall_lvl = cmp_lvl[2*NUM_WARN-1:NUM_WARN];
  assign sd_trip_lvl = cmp_lvl[2*NUM_WARN];
  assign sd_release_lvl = cmp_lvl[2*NUM_WARN+1];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      ttm_debounce u_db (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .sample_en_i(mon_power_o),
        .clear_i(cmp_clear[gi]),
        .raw_i(cmp_raw[gi]),
        .level_o(cmp_lvl[gi])
      );
    end
  endgenerate

  // sampling timer and monitor power
  assign window = (sample_cnt < SAMPLE_CNT_W'(SAMPLE_WINDOW));

  always_comb begin
    if (sample_cnt == SAMPLE_CNT_W'(SAMPLE_INTERVAL - 1)) begin
      next_sample_cnt = '0;
    end else begin
      next_sample_cnt = sample_cnt + 1'b1;
    end
    next_mon_power = 1'b0;
    if (temp_monitor_enable) begin
      // always on in run, standby samples only
      if (run_state_i && temp_monitor_always_on) begin
        next_mon_power = 1'b1;
      end else begin
        next_mon_power = window;
      end
    end
    // keep sensing during shutdown so cooling is seen
    if (thermal_shutdown_o) begin
      next_mon_power = 1'b1;
    end
  end

  // shutdown and restart lockout
  always_comb begin
    next_shutdown = thermal_shutdown_o;
    if (sd_trip_lvl) begin
      next_shutdown = 1'b1;
    // release only after cooling past hysteresis
    end else if (!sd_release_lvl) begin
      next_shutdown = 1'b0;
    end
  end

  // sense, flags and interrupt pin
  always_comb begin
    for (int i = 0; i < NUM_WARN; i++) begin
      // hold on falling until release comparator drops
      if (thermal_warn_sense[i]) begin
        next_sense[i] = fall_lvl[i];
      end else begin
        next_sense[i] = rise_lvl[i];
      end
    end
    if (!temp_monitor_enable) begin
      next_sense = '0;
    end
    warn_rise = next_sense & ~thermal_warn_sense;
    next_flag = (thermal_warn_irq_flag & ~flag_clr) | warn_rise;
    // unmasked flags drive the active-low pin
    next_irq_n = ~|(thermal_warn_irq_flag & ~thermal_warn_irq_mask);
  end

  // wishbone slave
  assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign flag_wr = wr_commit && (wb_adr_i == REG_FLAG);
  assign flag_clr = flag_wr ? wb_dat_i[NUM_WARN-1:0] : '0;

  always_comb begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = 32'h0;
    unique case (wb_adr_i)
      REG_CTRL: begin
        next_dat[CTRL_ENABLE_BIT] = temp_monitor_enable;
        next_dat[CTRL_AON_BIT] = temp_monitor_always_on;
      end
      REG_FLAG: next_dat[NUM_WARN-1:0] = thermal_warn_irq_flag;
      REG_SENSE: begin
        next_dat[NUM_WARN-1:0] = thermal_warn_sense;
        next_dat[STAT_SHUTDOWN_BIT] = thermal_shutdown_o;
        next_dat[STAT_POWER_BIT] = mon_power_o;
      end
      REG_MASK: next_dat[NUM_WARN-1:0] = thermal_warn_irq_mask;
      default: next_dat = 32'h0;
    endcase
    if (!next_ack) begin
      next_dat = wb_dat_o;
    end
    next_enable = temp_monitor_enable;
    next_always_on = temp_monitor_always_on;
    next_mask = thermal_warn_irq_mask;
    if (wr_commit && (wb_adr_i == REG_CTRL)) begin
      next_enable = wb_dat_i[CTRL_ENABLE_BIT];
      next_always_on = wb_dat_i[CTRL_AON_BIT];
    end
    if (wr_commit && (wb_adr_i == REG_MASK)) begin
      next_mask = wb_dat_i[NUM_WARN-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      temp_monitor_enable <= RST_ENABLE;
      temp_monitor_always_on <= RST_AON;
      thermal_warn_irq_mask <= RST_MASK;
      thermal_warn_irq_flag <= RST_FLAG;
      thermal_warn_sense <= '0;
      sample_cnt <= '0;
      mon_power_o <= 1'b0;
      thermal_shutdown_o <= 1'b0;
      irq_out_n_o <= 1'b1;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      temp_monitor_enable <= next_enable;
      temp_monitor_always_on <= next_always_on;
      thermal_warn_irq_mask <= next_mask;
      thermal_warn_irq_flag <= next_flag;
      thermal_warn_sense <= next_sense;
      sample_cnt <= next_sample_cnt;
      mon_power_o <= next_mon_power;
      thermal_shutdown_o <= next_shutdown;
      irq_out_n_o <= next_irq_n;
    end
  end

  a_irq_pin_mask: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ##1 (irq_out_n_o == !$past(|(thermal_warn_irq_flag & ~thermal_warn_irq_mask))))
    else $error("interrupt pin does not follow unmasked flags");

  a_flag_set_edge: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (|warn_rise) |=> ((thermal_warn_irq_flag & $past(warn_rise)) == $past(warn_rise)))
    else $error("flag not set on threshold crossing");

  a_flag_latched: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !flag_wr |=> ((thermal_warn_irq_flag & $past(thermal_warn_irq_flag)) == $past(thermal_warn_irq_flag)))
    else $error("flag dropped without software clear");

  a_flag_w1c: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (flag_wr && (warn_rise == '0)) |=> ((thermal_warn_irq_flag & $past(wb_dat_i[NUM_WARN-1:0])) == '0))
    else $error("write of one did not clear flag");

  a_sense_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (temp_monitor_enable && thermal_warn_sense[0] && fall_lvl[0]) |=> thermal_warn_sense[0])
    else $error("sense released above hysteresis point");

  a_sd_trip: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    sd_trip_lvl |=> thermal_shutdown_o)
    else $error("shutdown not started on trip");

  a_sd_lockout: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (thermal_shutdown_o && sd_release_lvl) |=> thermal_shutdown_o)
    else $error("shutdown released before hysteresis");

  a_mon_disabled: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!temp_monitor_enable && !thermal_shutdown_o) |=> !mon_power_o)
    else $error("monitor powered while disabled");

  a_aon_run: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (temp_monitor_enable && temp_monitor_always_on && run_state_i) |=> mon_power_o)
    else $error("monitor not continuous in run always-on");

  // interval wraps to a new window
  a_interval_wrap: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (sample_cnt == SAMPLE_CNT_W'(SAMPLE_INTERVAL - 1)) |=> (sample_cnt == '0) && window)
    else $error("sampling interval did not wrap");

  // standby samples only inside the window
  a_standby_duty: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!run_state_i && !window && !thermal_shutdown_o) |=> !mon_power_o)
    else $error("monitor on outside window in standby");
endmodule

/* File: common/ttm_pkg.sv */
// constants shared by the thermal threshold monitor files
package ttm_pkg;
  localparam int NUM_WARN = 6;
  localparam int CLK_MHZ = 50;
  // nominal warning thresholds in degrees C, lowest first
  localparam int WARN_DEG_0 = 80;
  localparam int WARN_DEG_1 = 95;
  localparam int WARN_DEG_2 = 110;
  localparam int WARN_DEG_3 = 125;
  localparam int WARN_DEG_4 = 140;
  localparam int WARN_DEG_5 = 155;
  localparam int WARN_HYST_DEG = 5;
  localparam int SHUTDOWN_DEG = 165;
  localparam int SHUTDOWN_HYST_DEG = 15;

  // timing
  localparam int DEBOUNCE_US = 10;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int SAMPLE_INTERVAL_US = 3000;
  localparam int SAMPLE_INTERVAL_CYC = SAMPLE_INTERVAL_US * CLK_MHZ;
  localparam int SAMPLE_WINDOW_US = 450;
  localparam int SAMPLE_WINDOW_CYC = SAMPLE_WINDOW_US * CLK_MHZ;
  localparam int SAMPLE_CNT_W = 18;
  localparam int DEBOUNCE_CNT_W = 10;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAG = 8'h04;
  localparam logic [7:0] REG_SENSE = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_AON_BIT = 1;
  localparam int STAT_SHUTDOWN_BIT = 8;
  localparam int STAT_POWER_BIT = 9;

  // reset values
  localparam logic RST_ENABLE = 1'b1;
  localparam logic RST_AON = 1'b0;
  localparam logic [5:0] RST_MASK = 6'h00;
  localparam logic [5:0] RST_FLAG = 6'h00;
endpackage

/* File: verilog/ttm_debounce.sv */
// three-flop synchroniser and bidirectional debounce for one comparator
module ttm_debounce (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic sample_en_i,
  input wire logic clear_i,
  input wire logic raw_i,
  output logic level_o
);
  import ttm_pkg::*;

  logic [2:0] sync;
  logic [DEBOUNCE_CNT_W-1:0] cnt;
  logic [2:0] next_sync;
  logic [DEBOUNCE_CNT_W-1:0] next_cnt;
  logic next_level;
  logic agree;

  assign agree = (sync[1] == sync[2]);

  always_comb begin
    next_sync = {sync[1:0], raw_i};
    next_cnt = '0;
    next_level = level_o;
    if (clear_i) begin
      next_level = 1'b0;
    end else if (!sample_en_i) begin
      // monitor unpowered: freeze the last decision
      next_cnt = cnt;
    end else if (agree && (sync[2] != level_o)) begin
      if (cnt == DEBOUNCE_CNT_W'(DEBOUNCE_CYC - 1)) begin
        next_level = sync[2];
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sync <= 3'h0;
      cnt <= '0;
      level_o <= 1'b0;
    end else begin
      sync <= next_sync;
      cnt <= next_cnt;
      level_o <= next_level;
    end
  end

  a_db_settle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!clear_i && (next_level != level_o)) |-> (cnt == DEBOUNCE_CNT_W'(DEBOUNCE_CYC - 1)))
    else $error("level changed before debounce time");
endmodule

/* File: tb/ttm_sensor_model.sv */
// behavioural model of the die temperature sensor and its comparators
module ttm_sensor_model (
  input wire logic ref_clk_i,
  input wire logic mon_power_i,
  input wire logic signed [15:0] temp_i,
  output logic [ttm_pkg::NUM_WARN-1:0] warn_rise_o,
  output logic [ttm_pkg::NUM_WARN-1:0] warn_fall_o,
  output logic sd_trip_o,
  output logic sd_release_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import ttm_pkg::*;
  localparam int WARN_DEG [NUM_WARN] = '{WARN_DEG_0, WARN_DEG_1, WARN_DEG_2, WARN_DEG_3, WARN_DEG_4, WARN_DEG_5};
  logic idle_pat = 1'b0;
  // unpowered comparators give a toggling pattern
  always @(posedge ref_clk_i) begin
    idle_pat <= ~idle_pat;
  end
  always_comb begin
    for (int i = 0; i < NUM_WARN; i++) begin
      warn_rise_o[i] = mon_power_i ? (int'(temp_i) >= WARN_DEG[i]) : idle_pat;
      warn_fall_o[i] = mon_power_i ? (int'(temp_i) >= WARN_DEG[i] - WARN_HYST_DEG) : ~idle_pat;
    end
    sd_trip_o = mon_power_i ? (int'(temp_i) >= SHUTDOWN_DEG) : idle_pat;
    sd_release_o = mon_power_i ? (int'(temp_i) >= SHUTDOWN_DEG - SHUTDOWN_HYST_DEG) : ~idle_pat;
  end
endmodule

/* File: tb/thermal_threshold_monitor_tb.sv */
// self-checking bench for the thermal threshold monitor
module thermal_threshold_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ttm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic run = 1'b1;
  logic ack, pwr, sd, irq_n, trip, rel;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic [5:0] rise, fall;
  logic signed [15:0] temp = 16'h0019;
  int num_errors = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  int row_t [9] = '{70, 80, 100, 78, 74, 156, 166, 152, 149};
  logic [9:0] row_s [9] = '{10'h200, 10'h201, 10'h203, 10'h201, 10'h200, 10'h23f, 10'h33f, 10'h33f, 10'h21f};

  ttm_thermal_monitor #(.SAMPLE_INTERVAL(2000), .SAMPLE_WINDOW(600)) ttm_thermal_monitor_i (
    .ref_clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .run_state_i(run),
    .warn_rise_cmp_i(rise), .warn_fall_cmp_i(fall), .sd_trip_cmp_i(trip), .sd_release_cmp_i(rel),
    .mon_power_o(pwr), .thermal_shutdown_o(sd), .irq_out_n_o(irq_n));
  ttm_sensor_model ttm_sensor_model_i (.ref_clk_i(clk), .mon_power_i(pwr), .temp_i(temp),
    .warn_rise_o(rise), .warn_fall_o(fall), .sd_trip_o(trip), .sd_release_o(rel));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic cnt(input int exp);
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    repeat (2000) begin
      @(posedge clk);
      n += int'(pwr === 1'b1);
    end
    chk(n, exp);
  endtask

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(REG_CTRL, 32'h1);
    rdchk(REG_MASK, 32'h0);
    rdchk(REG_FLAG, 32'h0);
    wb(1'b1, REG_SENSE, 32'h3f);
    wb(1'b0, REG_SENSE, 32'h0);
    chk(q & 32'h1ff, 32'h0);
    wb(1'b1, REG_CTRL, 32'h3);
    for (int i = 0; i < 9; i++) begin
      temp <= 16'(row_t[i]);
      repeat (530) @(posedge clk);
      rdchk(REG_SENSE, {22'h0, row_s[i]});
      chk(sd, row_s[i][8]);
    end
    temp <= 16'h009c;
    repeat (300) @(posedge clk);
    temp <= 16'h0095;
    repeat (600) @(posedge clk);
    rdchk(REG_SENSE, 32'h21f);
    temp <= 16'h009c;
    repeat (490) @(posedge clk);
    rdchk(REG_SENSE, 32'h21f);
    repeat (30) @(posedge clk);
    rdchk(REG_SENSE, 32'h23f);
    chk(irq_n, 32'h0);
    rdchk(REG_FLAG, 32'h3f);
    wb(1'b1, REG_MASK, 32'h3f);
    repeat (3) @(posedge clk);
    chk(irq_n, 32'h1);
    wb(1'b1, REG_FLAG, 32'h01);
    rdchk(REG_FLAG, 32'h3e);
    wb(1'b1, REG_FLAG, 32'h3e);
    wb(1'b1, REG_MASK, 32'h00);
    repeat (3) @(posedge clk);
    chk(irq_n, 32'h1);
    rdchk(8'h10, 32'h0);
    wb(1'b1, REG_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    rdchk(REG_SENSE, 32'h0);
    cnt(0);
    wb(1'b1, REG_CTRL, 32'h1);
    cnt(600);
    run <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h3);
    cnt(600);
    wb(1'b1, REG_CTRL, 32'h2);
    cnt(0);
    wb(1'b1, REG_CTRL, 32'h3);
    run <= 1'b1;
    cnt(2000);
    chk(irq_n, 32'h0);
    // mid-run reset back to defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({ack, sd, pwr, irq_n}, 32'h1);
    rst <= 1'b0;
    rdchk(REG_FLAG, 32'h0);
    rdchk(REG_CTRL, 32'h1);
    final_report();
  end
endmodule
